// ===== include/lwsp_pkg.sv
package lwsp_pkg;
  localparam int ADDR_W     = 10;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int DATA_W     = LANE_W * LANES;
  localparam int DEPTH      = 1 << ADDR_W;
  localparam int FIFO_DEPTH = 4;
  localparam int SLEEP_CYC  = 2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  typedef enum logic [1:0] {
    LWSP_IDLE,
    LWSP_READ,
    LWSP_WRITE
  } lwsp_op_t;
endpackage

// ===== verilog/lwsp_fifo.sv
`timescale 1ns/1ps
module lwsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;
  assign o_in_ready  = (cnt_q != DEPTH[PW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule // lwsp_fifo

// ===== verilog/lwsp_sram_port.sv
`timescale 1ns/1ps
module lwsp_sram_port
  import lwsp_pkg::*;
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // command pins
  input  wire logic              i_clock_enable_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_chip_select_one_n,
  input  wire logic              i_chip_select_two,
  input  wire logic              i_chip_select_three_n,
  input  wire logic              i_write_enable_n,
  input  wire logic [LANES-1:0]  i_lane_write_n,
  input  wire logic              i_advance_or_load,
  // asynchronous and strap pins
  input  wire logic              i_output_enable_n,
  input  wire logic              i_burst_order_select_n,
  input  wire logic              i_latency_mode_select,
  input  wire logic              i_sleep_request,
  // data pins, split three ways
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_oe_n,
  // status
  output logic                   o_asleep,
  output logic                   o_write_stall
);
  // write command path, fields and data joined
  localparam int CMD_W = ADDR_W + LANES;

  logic [DATA_W-1:0] mem_q [DEPTH];
  lwsp_op_t          op_q;
  logic              sel_q;
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        start_q;
  logic [1:0]        cnt_q;
  logic [LANES-1:0]  lanes_q;
  logic [CMD_W-1:0]  wp1_q;
  logic              wv1_q;
  logic [CMD_W-1:0]  wp2_q;
  logic              wv2_q;
  logic              rv1_q;
  logic [DATA_W-1:0] rd_q;
  logic              rdv_q;
  logic [1:0]        zz_cnt_q;
  logic              asleep_q;
  logic              pipe_q;

  // sleep gates the clock path along with clock enable
  wire edge_en = !i_clock_enable_n && !asleep_q;
  wire sel = !i_chip_select_one_n && i_chip_select_two
             && !i_chip_select_three_n;
  wire load = edge_en && !i_advance_or_load;
  wire advance_or_load  = edge_en && i_advance_or_load && sel_q;
  wire rd_cmd = load && sel && i_write_enable_n;
  wire wr_cmd = load && sel && !i_write_enable_n;
  wire adv_rd = advance_or_load && (op_q == LWSP_READ);
  wire adv_wr = advance_or_load && (op_q == LWSP_WRITE);
  wire pipe = i_latency_mode_select;

  // burst counter next value and address
  wire [1:0] cnt_nx = cnt_q + 2'h1;
  wire [1:0] low_lin = start_q + cnt_nx;
  wire [1:0] low_int = start_q ^ cnt_nx;
  wire [1:0] low_adv = i_burst_order_select_n ? low_int : low_lin;
  wire [ADDR_W-1:0] adv_addr = {base_q[ADDR_W-1:2], low_adv};
  wire [ADDR_W-1:0] cur_addr = load ? i_addr : adv_addr;
  wire [LANES-1:0] cur_lanes = load ? i_lane_write_n : lanes_q;
  wire any_rd = rd_cmd || adv_rd;
  // continued writes ignore the write pin; lane enables pick abort
  wire any_wr = wr_cmd || adv_wr;

  // write data stage: pipeline takes data two edges later
  wire [CMD_W-1:0] wr_due = pipe ? wp2_q : wp1_q;
  wire wr_due_v = pipe ? wv2_q : wv1_q;
  wire [ADDR_W-1:0] wd_addr = wr_due[CMD_W-1:LANES];
  wire [LANES-1:0]  wd_lanes = wr_due[LANES-1:0];

  // accepted writes queue up before the array commit
  logic              f_in_ready;
  logic              f_out_valid;
  logic [CMD_W+DATA_W-1:0] f_out;
  wire  [ADDR_W-1:0] c_addr = f_out[CMD_W+DATA_W-1:DATA_W+LANES];
  wire  [LANES-1:0]  c_lanes = f_out[DATA_W+LANES-1:DATA_W];
  wire  [DATA_W-1:0] c_data = f_out[DATA_W-1:0];
  // commit port is busy while a read uses the array this edge
  wire  c_ready = !any_rd;
  wire  push = edge_en && wr_due_v && (wd_lanes != {LANES{1'b1}});

  lwsp_fifo #(
    .WIDTH (CMD_W + DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .o_in_ready  (f_in_ready),
    .i_in_data   ({wr_due, i_data}),
    .o_out_valid (f_out_valid),
    .i_out_ready (c_ready),
    .o_out_data  (f_out)
  );
  // full queue would drop data; flagged for the controller
  assign o_write_stall = !f_in_ready;

  // lanes merged first so that one process owns the array
  wire [DATA_W-1:0] c_old = mem_q[c_addr];
  wire [DATA_W-1:0] c_merge;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign c_merge[g*LANE_W +: LANE_W] = c_lanes[g]
        ? c_old[g*LANE_W +: LANE_W] : c_data[g*LANE_W +: LANE_W];
    end
  endgenerate
  always_ff @(posedge i_sys_clk) begin
    if (f_out_valid && c_ready) begin
      mem_q[c_addr] <= c_merge;
    end
  end

  // read sees only the oldest queued write (queue head) when it hits its address
  logic [DATA_W-1:0] core_rd;
  always_comb begin
    core_rd = mem_q[cur_addr];
    if (f_out_valid && c_addr == cur_addr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!c_lanes[l]) core_rd[l*LANE_W +: LANE_W] =
          c_data[l*LANE_W +: LANE_W];
      end
    end
  end

  // command register and burst state
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      op_q    <= LWSP_IDLE;
      sel_q   <= 1'b0;
      base_q  <= '0;
      start_q <= 2'h0;
      cnt_q   <= 2'h0;
      lanes_q <= '1;
    end else if (load) begin
      op_q    <= sel ? (i_write_enable_n ? LWSP_READ : LWSP_WRITE)
                     : LWSP_IDLE;
      sel_q   <= sel;
      base_q  <= i_addr;
      start_q <= i_addr[1:0];
      cnt_q   <= 2'h0;
      lanes_q <= i_lane_write_n;
    end else if (advance_or_load) begin
      cnt_q   <= cnt_nx;
      lanes_q <= i_lane_write_n;
    end
  end

  // write delay line; frozen on ignored edges
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp1_q <= '0;
      wv1_q <= 1'b0;
      wp2_q <= '0;
      wv2_q <= 1'b0;
    end else if (edge_en) begin
      wp1_q <= {cur_addr, advance_or_load ? i_lane_write_n : cur_lanes};
      wv1_q <= any_wr;
      wp2_q <= wp1_q;
      wv2_q <= wv1_q;
    end
  end

  // read data stage
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rv1_q  <= 1'b0;
      rd_q   <= '0;
      rdv_q  <= 1'b0;
      pipe_q <= 1'b1;
    end else if (edge_en) begin
      pipe_q <= pipe;
      rv1_q  <= any_rd;
      rdv_q  <= pipe ? rv1_q : any_rd;
      if (any_rd) begin
        rd_q <= core_rd;
      end
    end
  end

  // pipeline adds one register stage on the output side
  logic [DATA_W-1:0] out_q;
  logic              outv_q;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_q  <= '0;
      outv_q <= 1'b0;
    end else if (edge_en) begin
      out_q  <= rd_q;
      outv_q <= rv1_q;
    end
  end

  // flow-through drives as soon as data is fetched
  assign o_data = pipe_q ? out_q : rd_q;
  wire drive = pipe_q ? outv_q : rdv_q;
  assign o_data_oe_n = !drive || i_output_enable_n || asleep_q;

  // sleep: two-cycle entry and two-cycle wake, state kept
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      zz_cnt_q <= SLEEP_CNT_RST;
      asleep_q <= 1'b0;
    end else if (i_sleep_request != asleep_q) begin
      if (zz_cnt_q == 2'(SLEEP_CYC - 1)) begin
        asleep_q <= i_sleep_request;
        zz_cnt_q <= SLEEP_CNT_RST;
      end else begin
        zz_cnt_q <= zz_cnt_q + 2'h1;
      end
    end else begin
      zz_cnt_q <= SLEEP_CNT_RST;
    end
  end
  assign o_asleep = asleep_q;

endmodule // lwsp_sram_port

// ===== sim/lwsp_sram_port_monitor.sv
`timescale 1ns/1ps
module lwsp_sram_port_monitor
  import lwsp_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_clock_enable_n,
  input wire logic              i_chip_select_one_n,
  input wire logic              i_chip_select_two,
  input wire logic              i_chip_select_three_n,
  input wire logic              i_write_enable_n,
  input wire logic              i_advance_or_load,
  input wire logic              i_output_enable_n,
  input wire logic              i_latency_mode_select,
  input wire logic              i_sleep_request,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic              o_data_oe_n,
  input wire logic              o_asleep
);
  logic sel, ld, rd, wr, ds;
  assign sel = !i_chip_select_one_n && i_chip_select_two
    && !i_chip_select_three_n;
  assign ld = !i_clock_enable_n && !i_advance_or_load && !o_asleep;
  assign rd = ld && sel && i_write_enable_n && !i_sleep_request;
  assign wr = ld && sel && !i_write_enable_n;
  assign ds = ld && !sel;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  chk_oe_pin_off: assert property (i_output_enable_n |-> o_data_oe_n)
    else $error("data driven with output enable high");
  chk_pipe_read: assert property (rd && i_latency_mode_select
    ##1 !i_clock_enable_n ##1 !i_output_enable_n |-> !o_data_oe_n)
    else $error("pipelined read data not driven");
  chk_flow_read: assert property (rd && !i_latency_mode_select
    ##1 !i_output_enable_n |-> !o_data_oe_n)
    else $error("flow-through read data not driven");
  chk_pipe_wr_off: assert property (wr && i_latency_mode_select
    ##1 !i_clock_enable_n |=> o_data_oe_n)
    else $error("bus driven in pipelined write data cycle");
  chk_desel_off: assert property (ds ##1 ds |=> o_data_oe_n)
    else $error("bus driven after deselect");
  chk_stall_hold: assert property (i_clock_enable_n
    && !i_sleep_request |=> $stable(o_data))
    else $error("output changed on ignored edge");
  chk_sleep_enter: assert property (i_sleep_request [*4] |-> o_asleep)
    else $error("sleep not entered");
  chk_sleep_leave: assert property (!i_sleep_request [*4] |-> !o_asleep)
    else $error("sleep not left");
  cover property (rd && i_latency_mode_select);
  cover property (rd && !i_latency_mode_select);
  cover property (o_asleep);
endmodule // lwsp_sram_port_monitor
bind lwsp_sram_port lwsp_sram_port_monitor u_mon (.*);

// ===== sim/lwsp_ctrl_model.sv
`timescale 1ns/1ps
module lwsp_ctrl_model
  import lwsp_pkg::*;
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_pipe,
  output logic [2:0]        o_cs,
  output logic              o_ce_n,
  output logic              o_we_n,
  output logic              o_adv,
  output logic [LANES-1:0]  o_ln,
  output logic [ADDR_W-1:0] o_a,
  output logic [DATA_W-1:0] o_d
);
  logic [DATA_W-1:0] s0, s1, dn;
  initial begin
    {o_cs, o_ce_n, o_we_n, o_adv} = 6'h2a;
    o_ln = '1;
    o_a = '0;
    o_d = '0;
    s0 = '0;
    s1 = '0;
  end
  // late write data: idle cycles carry a flipping pattern, never stale data
  always @(posedge i_sys_clk) begin
    dn = i_pipe ? s1 : s0;
    s1 = s0;
    s0 = ~s0;
    #1 o_d = dn;
  end
  task automatic op(input logic [5:0] c, input logic [LANES-1:0] ln,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    #1 {o_cs, o_ce_n, o_we_n, o_adv} = c;
    o_ln = ln;
    o_a = a;
    s0 = d;
  endtask
endmodule // lwsp_ctrl_model

// ===== sim/lwsp_sram_port_tb_top.sv
`timescale 1ns/1ps
module lwsp_sram_port_tb_top;
  import lwsp_pkg::*;
  localparam logic [5:0] RD = 6'h12, WR = 6'h10, AD = 6'h13;
  localparam logic [5:0] DS = 6'h2a, ST = 6'h16;
  localparam logic [DATA_W-1:0] D1 = 36'h123456789, D2 = 36'hfedcba987;
  logic clk, rst, oe_n, bo_n, lat, slp, ce_n, we_n, advance_or_load, dq_oe_n, zz, stl;
  logic [2:0]        cs;
  logic [LANES-1:0]  ln;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] d, q;
  int n, n_fail, tests_run, cyc;
  lwsp_ctrl_model m (.i_sys_clk(clk), .i_pipe(lat), .o_cs(cs),
    .o_ce_n(ce_n), .o_we_n(we_n), .o_adv(advance_or_load), .o_ln(ln), .o_a(a), .o_d(d));
  lwsp_sram_port dut (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_clock_enable_n(ce_n), .i_addr(a), .i_chip_select_one_n(cs[2]),
    .i_chip_select_two(cs[1]), .i_chip_select_three_n(cs[0]),
    .i_write_enable_n(we_n), .i_lane_write_n(ln), .i_advance_or_load(advance_or_load),
    .i_output_enable_n(oe_n), .i_burst_order_select_n(bo_n),
    .i_latency_mode_select(lat), .i_sleep_request(slp), .i_data(d),
    .o_data(q), .o_data_oe_n(dq_oe_n), .o_asleep(zz), .o_write_stall(stl));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [DATA_W:0] got, input logic [DATA_W:0] e);
    tests_run++;
    if (got !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] ra, logic [DATA_W-1:0] e);
    m.op(RD, '1, ra, '0);
    repeat (n) m.op(DS, '1, '0, '0);
    #2 chk({dq_oe_n, q}, {1'b0, e});
  endtask
  task automatic t_rw;
    for (int l = 0; l < 2; l++) begin
      m.op(DS, '1, '0, '0);
      lat = l[0];
      n = l + 1;
      m.op(WR, 4'h0, 10'h10, D1);
      m.op(WR, 4'h0, 10'h11, D2);
      m.op(WR, 4'h0, 10'h12, D2);
      m.op(WR, 4'hb, 10'h12, D1);
      rd_chk(10'h10, D1);
      m.op(RD, '1, 10'h11, '0);
      m.op(WR, 4'hf, 10'h11, D1);
      repeat (n - 1) m.op(DS, '1, '0, '0);
      #2 chk({dq_oe_n, q}, {1'b0, D2});
      for (int i = 0; i < 3; i++) m.op({3'h2 ^ 3'(1 << i), 3'h0}, 4'h0,
        10'h10, D2);
      repeat (3) m.op(DS, '1, '0, '0);
      rd_chk(10'h11, D2);
      rd_chk(10'h12, {D2[35:27], D1[26:18], D2[17:0]});
      rd_chk(10'h10, D1);
    end
    $display("read write done");
  endtask
  task automatic t_burst;
    bo_n = 0;
    for (int k = 0; k < 4; k++) m.op(k > 0 ? AD : WR, 4'h0, 10'h23,
      36'h100 + 36'((3 + k) % 4));
    repeat (3) m.op(DS, '1, '0, '0);
    bo_n = 1;
    for (int k = 0; k < 4 + n; k++) begin
      m.op(k == 0 ? RD : (k < 4 ? AD : DS), '1, 10'h21, '0);
      if (k >= n) #2 chk({dq_oe_n, q}, {1'b0, 36'h100 + 36'(1 ^ (k - n))});
    end
    $display("burst done");
  endtask
  task automatic t_stall;
    m.op(RD, '1, 10'h10, '0);
    m.op(DS, '1, '0, '0);
    m.op(ST, '1, '0, '0);
    #2 chk({dq_oe_n, q}, {1'b0, D1});
    m.op(ST, '1, '0, '0);
    #2 chk({dq_oe_n, q}, {1'b0, D1});
    oe_n = 1;
    #1 chk({36'h0, dq_oe_n}, 37'h1);
    m.op(DS, '1, '0, '0);
    oe_n = 0;
    $display("stall done");
  endtask
  task automatic t_sleep;
    slp = 1;
    repeat (4) m.op(DS, '1, '0, '0);
    chk({36'h0, zz}, 37'h1);
    m.op(WR, 4'h0, 10'h10, D2);
    slp = 0;
    repeat (4) m.op(DS, '1, '0, '0);
    chk({35'h0, zz, stl}, 37'h0);
    rd_chk(10'h10, D1);
    $display("sleep done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      wrap_up;
    end
  end
  initial begin
    {rst, oe_n, bo_n, lat, slp} = 5'h12;
    {n, n_fail, tests_run, cyc} = {32'd2, 96'd0};
    repeat (2) @(posedge clk);
    #1 rst = 0;
    t_rw;
    t_burst;
    t_stall;
    t_sleep;
    wrap_up;
  end
endmodule // lwsp_sram_port_tb_top
